// ===== rtl/suig_top.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module suig_top #(
  parameter int NUM_CH = suig_pkg::NUM_CH,
  parameter int REF_CLK_HZ = suig_pkg::REF_CLK_HZ
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  // Register port
  input wire logic [suig_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [suig_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [suig_pkg::DATA_W-1:0] REG_RDATA_O,
  // Channel engine
  input wire logic [NUM_CH-1:0] CHAN_DONE_I,
  input wire suig_pkg::suig_err_t [NUM_CH-1:0] CHAN_ERR_I,
  output logic [NUM_CH-1:0] CHAN_BUSY_O,
  output suig_pkg::suig_cfga_t [NUM_CH-1:0] CHAN_CFGA_O,
  output suig_pkg::suig_cfgb_t [NUM_CH-1:0] CHAN_CFGB_O,
  // Interrupt
  output logic IRQ_O
);

  // Channel decode and the flag layout assume exactly eight channels
  if (NUM_CH != suig_pkg::NUM_CH) begin : g_bad_ch
    $error("NUM_CH must be 8");
  end

  logic [suig_pkg::GLB_W-1:0] irq_enable;
  logic [suig_pkg::GLB_W-1:0] irq_flags;
  logic [suig_pkg::GLB_W-1:0] flag_set;
  logic [suig_pkg::GLB_W-1:0] flag_clr;
  logic [2:0] ch_idx;
  logic wr_gie;
  logic wr_gif;
  logic wr_cfga;
  logic wr_cfgb;
  logic wr_chst;
  logic srst_req;
  logic cfg_write;
  logic cand_ok;
  suig_pkg::suig_cfga_t cand_a;
  suig_pkg::suig_cfgb_t cand_b;
  logic [NUM_CH-1:0] req_bits;
  logic [NUM_CH-1:0] serviced_evt;
  logic [NUM_CH-1:0] serviced_q;
  logic [NUM_CH-1:0] err_any;
  logic [NUM_CH-1:0] err_q;
  logic cfg_ok;
  logic srst_done;
  logic [suig_pkg::CHST_W-1:0] chst [NUM_CH];
  logic [suig_pkg::DATA_W-1:0] next_rdata;

  // Address decode
  always_comb begin
    ch_idx = REG_ADDR_I[2:0];
    wr_gie = REG_WR_I && (REG_ADDR_I == suig_pkg::OFF_GIE);
    wr_gif = REG_WR_I && (REG_ADDR_I == suig_pkg::OFF_GIF);
    srst_req = REG_WR_I && (REG_ADDR_I == suig_pkg::OFF_SRST) && REG_WDATA_I[0];
    req_bits = (REG_WR_I && (REG_ADDR_I == suig_pkg::OFF_CHREQ)) ?
               REG_WDATA_I[NUM_CH-1:0] : '0;
    wr_cfga = REG_WR_I && (REG_ADDR_I[7:3] == suig_pkg::OFF_CFGA_BASE[7:3]);
    wr_cfgb = REG_WR_I && (REG_ADDR_I[7:3] == suig_pkg::OFF_CFGB_BASE[7:3]);
    wr_chst = REG_WR_I && (REG_ADDR_I[7:3] == suig_pkg::OFF_CHST_BASE[7:3]);
    cfg_write = wr_cfga || wr_cfgb;
  end

  // A write to one half is judged together with the other stored half
  always_comb begin
    cand_a = CHAN_CFGA_O[ch_idx];
    cand_b = CHAN_CFGB_O[ch_idx];
    if (wr_cfga) begin
      cand_a = suig_pkg::suig_cfga_t'(REG_WDATA_I[13:0]);
    end
    if (wr_cfgb) begin
      cand_b = suig_pkg::suig_cfgb_t'(REG_WDATA_I);
    end
  end

  suig_cfg_check #(
    .REF_CLK_HZ(REF_CLK_HZ)
  ) u_check (
    .cfga_i(cand_a),
    .cfgb_i(cand_b),
    .valid_o(cand_ok)
  );

  // Global enable; upper bits are not stored
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      irq_enable <= suig_pkg::GIE_RST;
    end else if (wr_gie) begin
      irq_enable <= REG_WDATA_I[suig_pkg::GLB_W-1:0];
    end
  end

  // Channel settings; an invalid set is refused and the old one kept
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I || srst_req) begin
      for (int n = 0; n < NUM_CH; n++) begin
        CHAN_CFGA_O[n] <= suig_pkg::suig_cfga_t'(suig_pkg::CFGA_RST);
        CHAN_CFGB_O[n] <= suig_pkg::suig_cfgb_t'(suig_pkg::CFGB_RST);
      end
    end else if (cfg_write && cand_ok) begin
      CHAN_CFGA_O[ch_idx] <= cand_a;
      CHAN_CFGB_O[ch_idx] <= cand_b;
    end
  end

  // Configuration and soft reset completion, one cycle after the work
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      cfg_ok <= 1'b0;
      srst_done <= 1'b0;
    end else begin
      cfg_ok <= cfg_write && cand_ok;
      srst_done <= srst_req;
    end
  end

  // Outstanding requests; a new request beats a completion
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I || srst_req) begin
      CHAN_BUSY_O <= '0;
    end else begin
      CHAN_BUSY_O <= (CHAN_BUSY_O & ~CHAN_DONE_I) | req_bits;
    end
  end

  // Completions without a request are ignored
  always_comb begin
    serviced_evt = CHAN_DONE_I & CHAN_BUSY_O;
  end

  // Second stage so the global flag trails the channel status
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      serviced_q <= '0;
      err_q <= '0;
    end else begin
      serviced_q <= serviced_evt;
      err_q <= err_any;
    end
  end

  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    logic [suig_pkg::CHST_W-1:0] st_set;
    logic [suig_pkg::CHST_W-1:0] st_clr;
    suig_pkg::suig_err_t err_gated;

    always_comb begin
      err_gated.break_err = CHAN_ERR_I[n].break_err &&
                            CHAN_CFGB_O[n].break_irq_enable;
      err_gated.framing_err = CHAN_ERR_I[n].framing_err &&
                              CHAN_CFGB_O[n].framing_irq_enable;
      err_gated.parity_err = CHAN_ERR_I[n].parity_err &&
                             CHAN_CFGB_O[n].parity_irq_enable;
      err_any[n] = |err_gated;
      st_set = '0;
      st_set[suig_pkg::ST_SERVICED] = serviced_evt[n];
      st_set[suig_pkg::ST_BREAK] = err_gated.break_err;
      st_set[suig_pkg::ST_FRAMING] = err_gated.framing_err;
      st_set[suig_pkg::ST_PARITY] = err_gated.parity_err;
      st_set[suig_pkg::ST_REJECT] = cfg_write && !cand_ok && (ch_idx == 3'(n));
      st_clr = '0;
      if (srst_req) begin
        st_clr = '1;
      end else if (wr_chst && (ch_idx == 3'(n))) begin
        st_clr = REG_WDATA_I[suig_pkg::CHST_W-1:0];
      end
    end

    suig_sticky #(
      .W(suig_pkg::CHST_W)
    ) u_chst (
      .clk_i(CORE_CLK_I),
      .nrst_i(NRST_I),
      .set_i(st_set),
      .clr_i(st_clr),
      .q_o(chst[n])
    );
  end

  always_comb begin
    flag_set = '0;
    flag_set[NUM_CH-1:0] = serviced_q;
    flag_set[suig_pkg::BIT_SRST] = srst_done;
    flag_set[suig_pkg::BIT_ERR] = |err_q;
    flag_set[suig_pkg::BIT_CONF] = cfg_ok;
    flag_clr = wr_gif ? REG_WDATA_I[suig_pkg::GLB_W-1:0] : '0;
  end

  suig_sticky #(
    .W(suig_pkg::GLB_W)
  ) u_flags (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .set_i(flag_set),
    .clr_i(flag_clr),
    .q_o(irq_flags)
  );

  // Error flag is one for all channels, so the global enable gates them all
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_flags & irq_enable);
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    next_rdata = '0;
    if (REG_RD_I) begin
      if (REG_ADDR_I == suig_pkg::OFF_GIE) begin
        next_rdata[suig_pkg::GLB_W-1:0] = irq_enable;
      end else if (REG_ADDR_I == suig_pkg::OFF_GIF) begin
        next_rdata[suig_pkg::GLB_W-1:0] = irq_flags;
      end else if (REG_ADDR_I == suig_pkg::OFF_CHREQ) begin
        next_rdata[NUM_CH-1:0] = CHAN_BUSY_O;
      end else if (REG_ADDR_I[7:3] == suig_pkg::OFF_CFGA_BASE[7:3]) begin
        next_rdata[13:0] = CHAN_CFGA_O[ch_idx];
      end else if (REG_ADDR_I[7:3] == suig_pkg::OFF_CFGB_BASE[7:3]) begin
        next_rdata = CHAN_CFGB_O[ch_idx];
      end else if (REG_ADDR_I[7:3] == suig_pkg::OFF_CHST_BASE[7:3]) begin
        next_rdata[suig_pkg::CHST_W-1:0] = chst[ch_idx];
        next_rdata[suig_pkg::CHST_W] = CHAN_BUSY_O[ch_idx];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      REG_RDATA_O <= '0;
    end else begin
      REG_RDATA_O <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ===== common/suig_pkg.sv
package suig_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 8;
  localparam int GLB_W = 11;
  localparam int CHST_W = 5;
  localparam int REF_CLK_HZ = 50000000;

  // Fixed register addresses, so software always finds status here
  localparam logic [7:0] OFF_GIE = 8'h00;
  localparam logic [7:0] OFF_GIF = 8'h01;
  localparam logic [7:0] OFF_SRST = 8'h02;
  localparam logic [7:0] OFF_CHREQ = 8'h03;
  localparam logic [7:0] OFF_CFGA_BASE = 8'h10;
  localparam logic [7:0] OFF_CFGB_BASE = 8'h18;
  localparam logic [7:0] OFF_CHST_BASE = 8'h20;

  localparam int BIT_CONF = 10;
  localparam int BIT_ERR = 9;
  localparam int BIT_SRST = 8;

  localparam int ST_SERVICED = 0;
  localparam int ST_BREAK = 1;
  localparam int ST_FRAMING = 2;
  localparam int ST_PARITY = 3;
  localparam int ST_REJECT = 4;

  localparam logic [3:0] CHAR_LEN_MIN = 4'h6;
  localparam logic [3:0] CHAR_LEN_MAX = 4'hC;
  localparam int BAUD_MIN = 300;
  localparam int BAUD_MAX = 230400;

  localparam logic [1:0] OVS_NONE = 2'h0;
  localparam logic [1:0] OVS_X8 = 2'h1;
  localparam logic [1:0] OVS_X16 = 2'h2;
  localparam logic [1:0] OVS_RSVD = 2'h3;

  localparam logic [10:0] GIE_RST = 11'h000;
  localparam logic [13:0] CFGA_RST = 14'h0880;
  localparam logic [15:0] CFGB_RST = 16'h01FF;

  typedef struct packed {
    logic [1:0] oversample;
    logic [3:0] rx_char_length;
    logic [3:0] tx_char_length;
    logic [1:0] rx_lane_select;
    logic [1:0] tx_lane_select;
  } suig_cfga_t;

  typedef struct packed {
    logic parity_irq_enable;
    logic framing_irq_enable;
    logic break_irq_enable;
    logic [4:0] fine_bit_clock_divider;
    logic [7:0] coarse_bit_clock_divider;
  } suig_cfgb_t;

  typedef struct packed {
    logic parity_err;
    logic framing_err;
    logic break_err;
  } suig_err_t;

endpackage

// ===== rtl/suig_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module suig_sticky #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Events and clears
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  // Flags
  output logic [W-1:0] q_o
);

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q_o <= '0;
    end else begin
      q_o <= (q_o & ~clr_i) | set_i;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/suig_cfg_check.sv
`timescale 1ns/1ps
`default_nettype none
module suig_cfg_check #(
  parameter int REF_CLK_HZ = suig_pkg::REF_CLK_HZ
) (
  // Candidate settings
  input wire suig_pkg::suig_cfga_t cfga_i,
  input wire suig_pkg::suig_cfgb_t cfgb_i,
  // Verdict
  output logic valid_o
);

  logic [12:0] divisor;
  logic len_ok;
  logic baud_ok;

  always_comb begin
    divisor = 13'(cfgb_i.coarse_bit_clock_divider) * 13'(cfgb_i.fine_bit_clock_divider);
    len_ok = (cfga_i.tx_char_length >= suig_pkg::CHAR_LEN_MIN) &&
             (cfga_i.tx_char_length <= suig_pkg::CHAR_LEN_MAX) &&
             (cfga_i.rx_char_length >= suig_pkg::CHAR_LEN_MIN) &&
             (cfga_i.rx_char_length <= suig_pkg::CHAR_LEN_MAX);
    // Wide products avoid overflow for the largest divisor
    baud_ok = (divisor != 13'h0000) &&
              (48'(divisor) * 48'(suig_pkg::BAUD_MAX) >= 48'(REF_CLK_HZ)) &&
              (48'(divisor) * 48'(suig_pkg::BAUD_MIN) <= 48'(REF_CLK_HZ));
    valid_o = len_ok && baud_ok && (cfga_i.oversample != suig_pkg::OVS_RSVD);
  end

endmodule
`default_nettype wire

// ===== test/suig_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module suig_top_chk #(
  parameter int NUM_CH = suig_pkg::NUM_CH,
  parameter int REF_CLK_HZ = suig_pkg::REF_CLK_HZ
) (
  // Watched ports
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic [suig_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [suig_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [suig_pkg::DATA_W-1:0] REG_RDATA_O,
  input wire logic [NUM_CH-1:0] CHAN_DONE_I,
  input wire suig_pkg::suig_err_t [NUM_CH-1:0] CHAN_ERR_I,
  input wire logic [NUM_CH-1:0] CHAN_BUSY_O,
  input wire suig_pkg::suig_cfga_t [NUM_CH-1:0] CHAN_CFGA_O,
  input wire suig_pkg::suig_cfgb_t [NUM_CH-1:0] CHAN_CFGB_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  // Enable shadow rebuilt from host writes, as the enable is not a port
  logic [10:0] en_sh;
  logic req_wr;
  logic srst_wr;
  assign req_wr = REG_WR_I && (REG_ADDR_I == suig_pkg::OFF_CHREQ);
  assign srst_wr = REG_WR_I && (REG_ADDR_I == suig_pkg::OFF_SRST) && REG_WDATA_I[0];
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      en_sh <= 11'h000;
    end else if (REG_WR_I && (REG_ADDR_I == suig_pkg::OFF_GIE)) begin
      en_sh <= REG_WDATA_I[10:0];
    end
  end
  AST_RD_IDLE: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
    else $error("read data not idle");
  AST_RESV_ZERO: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) <= 8'h01
    |-> REG_RDATA_O[15:11] == 5'h00) else $error("reserved bits not zero");
  AST_REQ_BUSY: assert property (req_wr |=> (CHAN_BUSY_O & $past(REG_WDATA_I[NUM_CH-1:0]))
    == $past(REG_WDATA_I[NUM_CH-1:0])) else $error("request did not set busy");
  AST_DONE_FREE: assert property (CHAN_DONE_I[0] && CHAN_BUSY_O[0] && !req_wr
    |=> !CHAN_BUSY_O[0]) else $error("busy kept after done");
  AST_IRQ_MASKED: assert property ($past(en_sh) == 11'h000 |-> !IRQ_O)
    else $error("interrupt with all enables off");
  AST_CH_IRQ: assert property (CHAN_DONE_I[0] && CHAN_BUSY_O[0] && en_sh[0]
    |-> ##3 IRQ_O) else $error("channel interrupt late");
  AST_CFG_HOLD: assert property (!REG_WR_I |=> $stable(CHAN_CFGA_O) && $stable(CHAN_CFGB_O))
    else $error("settings changed without write");
  AST_LEN_RANGE: assert property (CHAN_CFGA_O[0].tx_char_length >= 4'h6
    && CHAN_CFGA_O[0].tx_char_length <= 4'hC && CHAN_CFGA_O[0].oversample != 2'h3)
    else $error("settings out of range");
  AST_SRST: assert property (srst_wr |=> CHAN_BUSY_O == '0)
    else $error("busy kept after soft reset");
  cover property (req_wr ##1 CHAN_BUSY_O != '0);
  cover property ($rose(IRQ_O));
  cover property (|CHAN_ERR_I);
endmodule
bind suig_top suig_top_chk #(.NUM_CH(NUM_CH), .REF_CLK_HZ(REF_CLK_HZ)) u_chk (
  .CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .CHAN_DONE_I(CHAN_DONE_I), .CHAN_ERR_I(CHAN_ERR_I),
  .CHAN_BUSY_O(CHAN_BUSY_O), .CHAN_CFGA_O(CHAN_CFGA_O), .CHAN_CFGB_O(CHAN_CFGB_O),
  .IRQ_O(IRQ_O));
`default_nettype wire

// ===== test/suig_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module suig_engine_model #(
  parameter int NUM_CH = suig_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Engine side of the block
  input wire logic [NUM_CH-1:0] busy_i,
  output logic [NUM_CH-1:0] done_o,
  output suig_pkg::suig_err_t [NUM_CH-1:0] err_o,
  // Bench controls
  input wire logic [NUM_CH-1:0] stall_i,
  input wire suig_pkg::suig_err_t [NUM_CH-1:0] err_req_i
);
  // Done only for a pending request; a stall models a slow engine
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      done_o <= '0;
    end else begin
      done_o <= busy_i & ~done_o & ~stall_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      err_o <= '0;
    end else begin
      err_o <= err_req_i;
    end
  end
endmodule
`default_nettype wire

// ===== test/test_suig_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_suig_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [7:0] done;
  logic [7:0] busy;
  logic [7:0] stall = 8'h00;
  logic irq;
  suig_pkg::suig_err_t [7:0] err;
  suig_pkg::suig_err_t [7:0] err_req = '0;
  int error_cnt = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  suig_top DUT (.CORE_CLK_I(clk), .NRST_I(nrst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .CHAN_DONE_I(done), .CHAN_ERR_I(err),
    .CHAN_BUSY_O(busy), .CHAN_CFGA_O(), .CHAN_CFGB_O(), .IRQ_O(irq));
  suig_engine_model u_eng (.clk_i(clk), .nrst_i(nrst), .busy_i(busy), .done_o(done),
    .err_o(err), .stall_i(stall), .err_req_i(err_req));
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic exp);
    check_count++;
    if (irq !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: interrupt %b, expected %b", $time, irq, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_reg(rdata, exp);
  endtask
  task automatic ev(input logic [2:0] e);
    @(posedge clk);
    err_req[0] <= e;
    @(posedge clk);
    err_req[0] <= 3'h0;
    cyc(4);
  endtask
  initial begin
    #100000;
    error_cnt++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h00, 16'h0000);
    rd_reg(8'h01, 16'h0000);
    rd_reg(8'h40, 16'h0000);
    wr_reg(8'h00, 16'hFFFF);
    rd_reg(8'h00, 16'h07FF);
    wr_reg(8'h00, 16'h0000);
    wr_reg(8'h03, 16'h0001);
    cyc(6);
    chk_irq(1'b0);
    rd_reg(8'h01, 16'h0001);
    wr_reg(8'h00, 16'h0001);
    cyc(2);
    chk_irq(1'b1);
    wr_reg(8'h01, 16'h0001);
    cyc(2);
    chk_irq(1'b0);
    stall <= 8'h08;
    wr_reg(8'h03, 16'h0008);
    wr_reg(8'h03, 16'h0001);
    cyc(4);
    rd_reg(8'h03, 16'h0008);
    stall <= 8'h00;
    wr_reg(8'h01, 16'h0001);
    cyc(6);
    chk_irq(1'b0);
    rd_reg(8'h03, 16'h0000);
    rd_reg(8'h23, 16'h0001);
    rd_reg(8'h01, 16'h0008);
    wr_reg(8'h01, 16'h07FF);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h10, {2'h0, i[1:0], 12'h880});
      rd_reg(8'h10, {2'h0, (i == 3) ? 2'h2 : i[1:0], 12'h880});
    end
    wr_reg(8'h01, 16'h07FF);
    wr_reg(8'h10, 16'h08D0);
    rd_reg(8'h10, 16'h2880);
    rd_reg(8'h01, 16'h0000);
    wr_reg(8'h10, 16'h0C65);
    rd_reg(8'h10, 16'h0C65);
    wr_reg(8'h18, 16'h0101);
    rd_reg(8'h18, 16'h01FF);
    wr_reg(8'h18, 16'h21FF);
    rd_reg(8'h18, 16'h21FF);
    rd_reg(8'h01, 16'h0400);
    wr_reg(8'h00, 16'h0400);
    cyc(2);
    chk_irq(1'b1);
    wr_reg(8'h01, 16'h07FF);
    ev(3'h2);
    rd_reg(8'h01, 16'h0000);
    ev(3'h1);
    rd_reg(8'h20, 16'h0013);
    wr_reg(8'h20, 16'h0001);
    rd_reg(8'h20, 16'h0012);
    rd_reg(8'h01, 16'h0200);
    chk_irq(1'b0);
    wr_reg(8'h00, 16'h0200);
    cyc(2);
    chk_irq(1'b1);
    wr_reg(8'h01, 16'h07FF);
    wr_reg(8'h02, 16'h0001);
    cyc(2);
    rd_reg(8'h10, 16'h0880);
    rd_reg(8'h20, 16'h0000);
    rd_reg(8'h01, 16'h0100);
    chk_irq(1'b0);
    wr_reg(8'h00, 16'h0100);
    cyc(2);
    chk_irq(1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
